// File: pkg/crhc_map.svh
// Named offsets, bit positions, reset values and timing counts of the core reset and halt block.
`ifndef CRHC_MAP_SVH
`define CRHC_MAP_SVH

`define CRHC_BUS_AW          8
`define CRHC_BUS_DW          32
`define CRHC_OFF_CTRL        8'h00
`define CRHC_OFF_STATUS      8'h04
`define CRHC_OFF_IRQ_STATUS  8'h08
`define CRHC_OFF_IRQ_CLEAR   8'h0c
`define CRHC_OFF_IRQ_ENABLE  8'h10
`define CRHC_OFF_DATA_ADDR   8'h14
`define CRHC_CTRL_HALT       0
`define CRHC_CTRL_CONTINUE   1
`define CRHC_ST_STATE_LSB    0
`define CRHC_ST_BOOT_LSB     2
`define CRHC_ST_HALTED       4
`define CRHC_ST_SLEEP        5
`define CRHC_ST_RST_SHORT    6
`define CRHC_EV_HALT         0
`define CRHC_EV_IRQ          1
`define CRHC_EV_RESUME       2
`define CRHC_NUM_EV          3
`define CRHC_EV_RESET        3'h0
`define CRHC_WORD_RESET      32'h0000_0000
`define CRHC_INSTR_STEP      32'h0000_0004
`define CRHC_IRQ_VEC_OFF     32'h0000_0010
`define CRHC_RST_HOLD_REC    5'h10
`define CRHC_RST_CNT_W       5
`define CRHC_RST_CNT_ONE     5'h01

`endif

// File: pkg/crhc_pkg.sv
// Types shared by the core reset and halt block.
package crhc_pkg;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_RUN   = 2'b01,
		ST_HALT  = 2'b11,
		ST_SLEEP = 2'b10
	} crhc_state_type;

	typedef enum logic [1:0] {
		BOOT_VECTOR     = 2'b00,
		BOOT_SLEEP      = 2'b01,
		BOOT_DEBUG_HALT = 2'b10,
		BOOT_SPARE      = 2'b11
	} crhc_boot_type;

endpackage

// File: pkg/crhc_ctl_if.sv
// Halt request path between the core control logic and its stop edge detector.
`timescale 1ns/10ps
`default_nettype none
interface crhc_ctl_if;
	logic dbg_stop;
	logic halt_req;
	modport halt (input dbg_stop, output halt_req);
	modport core (output dbg_stop, input halt_req);
endinterface
`default_nettype wire

// File: design/crhc_sync.sv
// Three flip-flop synchroniser that passes a level once the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
module crhc_sync (
	// Clock and reset.
	input  wire logic i_mclk,
	input  wire logic i_srst,
	// Level from another domain and its synchronised copy.
	input  wire logic i_async,
	output logic      o_level
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= i_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_level <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			o_level <= s3_reg;
		end
	end

	a_sync_agree_change: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) && $changed(o_level)
		|-> ($past(s2_reg) == $past(s3_reg)) && (o_level == $past(s3_reg)))
		else $error("Synchronised level changed without stage agreement.");

endmodule
`default_nettype wire

// File: design/crhc_halt_det.sv
// Rising edge detector for the debug stop input, active only with debug enabled.
`timescale 1ns/10ps
`default_nettype none
module crhc_halt_det #(
	parameter int DEBUG_LEVEL = 1
) (
	// Clock and reset.
	input  wire logic  i_mclk,
	input  wire logic  i_srst,
	// Stop level in, halt request pulse out.
	crhc_ctl_if.halt   ctl
);

	logic prev_reg;

	// A stop held high through reset is not taken as a fresh edge.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= ctl.dbg_stop;
		end
	end

	generate
		if (DEBUG_LEVEL > 0) begin : g_dbg_on
			assign ctl.halt_req = ctl.dbg_stop & ~prev_reg;
		end else begin : g_dbg_off
			assign ctl.halt_req = 1'b0;
		end
	endgenerate

	a_stop_ignored_off: assert property (@(posedge i_mclk) disable iff (i_srst)
		(DEBUG_LEVEL == 0) |-> !ctl.halt_req)
		else $error("Halt request raised with debug disabled.");

	a_stop_edge_pulse: assert property (@(posedge i_mclk) disable iff (i_srst)
		(DEBUG_LEVEL > 0) && ctl.dbg_stop && !$past(ctl.dbg_stop) && !$past(i_srst)
		|-> ctl.halt_req ##1 !ctl.halt_req)
		else $error("Stop rising edge did not give a single request pulse.");

endmodule
`default_nettype wire

// File: design/crhc_core_ctl.sv
// Reset, boot mode, interrupt input and debug halt control of a soft processor core.
`timescale 1ns/10ps
`default_nettype none
`include "crhc_map.svh"
module crhc_core_ctl #(
	parameter int              ADDR_W            = 32,
	parameter int              async_irq_param   = 1,
	parameter int              debug_level_param = 1,
	parameter logic [63:0]     vector_base_param = 64'h0
) (
	// Clock and reset.
	input  wire logic                     i_mclk,
	input  wire logic                     i_srst,
	// Register port.
	input  wire logic [`CRHC_BUS_AW-1:0]  i_addr,
	input  wire logic [`CRHC_BUS_DW-1:0]  i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [`CRHC_BUS_DW-1:0]  o_rdata,
	// Core control inputs.
	input  wire logic [1:0]               i_boot_mode,
	input  wire logic                     i_interrupt,
	input  wire logic                     i_dbg_stop,
	input  wire logic [1:0]               i_wakeup,
	// Core status outputs.
	output logic                          o_pipeline_halted_flag,
	output logic                          o_sleep,
	output logic                          o_irq,
	// Local memory bus addresses.
	output logic      [ADDR_W-1:0]        o_instr_addr,
	output logic      [ADDR_W-1:0]        o_data_addr
);

	crhc_pkg::crhc_state_type             state_reg;
	crhc_pkg::crhc_state_type             state_next;
	crhc_pkg::crhc_boot_type              boot_mode_reg;
	logic [ADDR_W-1:0]                    pc_reg;
	logic [ADDR_W-1:0]                    pc_next;
	logic [ADDR_W-1:0]                    vec_base;
	logic [`CRHC_BUS_DW-1:0]              data_addr_reg;
	logic [`CRHC_NUM_EV-1:0]              ev_status_reg;
	logic [`CRHC_NUM_EV-1:0]              ev_status_next;
	logic [`CRHC_NUM_EV-1:0]              ev_enable_reg;
	logic [`CRHC_NUM_EV-1:0]              ev_enable_next;
	logic [`CRHC_NUM_EV-1:0]              ev_set;
	logic [`CRHC_NUM_EV-1:0]              ev_clr;
	logic [`CRHC_RST_CNT_W-1:0]           rst_cnt_reg;
	logic                                 srst_d_reg;
	logic                                 rst_short_reg;
	logic                                 irq_lvl;
	logic                                 irq_prev_reg;
	logic                                 irq_rise;
	logic [1:0]                           wake_lvl;
	logic                                 sw_halt;
	logic                                 sw_cont;
	logic                                 halt_any;

	crhc_ctl_if ctl ();

	// Register decode used by the write and read paths.
	function automatic logic hit(input logic [`CRHC_BUS_AW-1:0] addr,
		input logic [`CRHC_BUS_AW-1:0] off);
		hit = (addr == off);
	endfunction

	assign vec_base = vector_base_param[ADDR_W-1:0];
	assign ctl.dbg_stop = i_dbg_stop;

	crhc_halt_det #(
		.DEBUG_LEVEL (debug_level_param)
	) u_halt_det (
		.i_mclk (i_mclk),
		.i_srst (i_srst),
		.ctl    (ctl.halt)
	);

	generate
		if (async_irq_param != 0) begin : g_irq_async
			crhc_sync u_irq_sync (
				.i_mclk  (i_mclk),
				.i_srst  (i_srst),
				.i_async (i_interrupt),
				.o_level (irq_lvl)
			);
		end else begin : g_irq_direct
			assign irq_lvl = i_interrupt;
		end
	endgenerate

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_wake
			crhc_sync u_wake_sync (
				.i_mclk  (i_mclk),
				.i_srst  (i_srst),
				.i_async (i_wakeup[gi]),
				.o_level (wake_lvl[gi])
			);
		end
	endgenerate

	// Software pulses from the control register.
	assign sw_halt = i_wr && hit(i_addr, `CRHC_OFF_CTRL) && i_wdata[`CRHC_CTRL_HALT] &&
		(debug_level_param > 0);
	assign sw_cont = i_wr && hit(i_addr, `CRHC_OFF_CTRL) && i_wdata[`CRHC_CTRL_CONTINUE];
	assign halt_any = ctl.halt_req || sw_halt;
	assign irq_rise = irq_lvl && !irq_prev_reg;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			boot_mode_reg <= crhc_pkg::crhc_boot_type'(i_boot_mode);
		end
	end

	// Reset length watch; a short reset still resets fully but is flagged.
	always_ff @(posedge i_mclk) begin
		srst_d_reg <= i_srst;
		if (i_srst) begin
			if (srst_d_reg) begin
				if (rst_cnt_reg != `CRHC_RST_HOLD_REC) begin
					rst_cnt_reg <= rst_cnt_reg + `CRHC_RST_CNT_ONE;
				end
			end else begin
				rst_cnt_reg <= `CRHC_RST_CNT_ONE;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_srst && srst_d_reg) begin
			rst_short_reg <= (rst_cnt_reg < `CRHC_RST_HOLD_REC);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			irq_prev_reg <= 1'b0;
		end else begin
			irq_prev_reg <= irq_lvl;
		end
	end

	// Pipeline state and fetch address.
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		case (state_reg)
			crhc_pkg::ST_RESET: begin
				pc_next = vec_base;
				case (boot_mode_reg)
					crhc_pkg::BOOT_SLEEP: begin
						state_next = crhc_pkg::ST_SLEEP;
					end
					crhc_pkg::BOOT_DEBUG_HALT: begin
						if (debug_level_param > 0) begin
							state_next = crhc_pkg::ST_HALT;
						end else begin
							state_next = crhc_pkg::ST_RUN;
						end
					end
					default: begin
						state_next = crhc_pkg::ST_RUN;
					end
				endcase
			end
			crhc_pkg::ST_RUN: begin
				if (halt_any) begin
					state_next = crhc_pkg::ST_HALT;
				end else if (irq_rise) begin
					pc_next = vec_base + ADDR_W'(`CRHC_IRQ_VEC_OFF);
				end else begin
					pc_next = pc_reg + ADDR_W'(`CRHC_INSTR_STEP);
				end
			end
			crhc_pkg::ST_HALT: begin
				if (sw_cont) begin
					state_next = crhc_pkg::ST_RUN;
				end
			end
			crhc_pkg::ST_SLEEP: begin
				if (halt_any) begin
					state_next = crhc_pkg::ST_HALT;
				end else if (|wake_lvl) begin
					state_next = crhc_pkg::ST_RUN;
				end
			end
			default: begin
				state_next = crhc_pkg::ST_RESET;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_reg <= crhc_pkg::ST_RESET;
			pc_reg <= '0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_pipeline_halted_flag <= 1'b0;
			o_sleep <= 1'b0;
			o_instr_addr <= '0;
		end else begin
			o_pipeline_halted_flag <= (state_next == crhc_pkg::ST_HALT);
			o_sleep <= (state_next == crhc_pkg::ST_SLEEP);
			o_instr_addr <= pc_next;
		end
	end

	// Data address register steers the data bus address output.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			data_addr_reg <= `CRHC_WORD_RESET;
			o_data_addr <= '0;
		end else begin
			if (i_wr && hit(i_addr, `CRHC_OFF_DATA_ADDR)) begin
				data_addr_reg <= i_wdata;
			end
			o_data_addr <= ADDR_W'(data_addr_reg);
		end
	end

	// Sticky events; a set in the clearing cycle survives.
	always_comb begin
		ev_set = '0;
		ev_set[`CRHC_EV_HALT] = (state_next == crhc_pkg::ST_HALT) &&
			(state_reg != crhc_pkg::ST_HALT);
		ev_set[`CRHC_EV_IRQ] = (state_reg == crhc_pkg::ST_RUN) && !halt_any && irq_rise;
		ev_set[`CRHC_EV_RESUME] = (state_reg == crhc_pkg::ST_HALT) &&
			(state_next == crhc_pkg::ST_RUN);
		ev_clr = '0;
		if (i_wr && hit(i_addr, `CRHC_OFF_IRQ_CLEAR)) begin
			ev_clr = i_wdata[`CRHC_NUM_EV-1:0];
		end
		ev_status_next = (ev_status_reg & ~ev_clr) | ev_set;
		ev_enable_next = ev_enable_reg;
		if (i_wr && hit(i_addr, `CRHC_OFF_IRQ_ENABLE)) begin
			ev_enable_next = i_wdata[`CRHC_NUM_EV-1:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			ev_status_reg <= `CRHC_EV_RESET;
			ev_enable_reg <= `CRHC_EV_RESET;
			o_irq <= 1'b0;
		end else begin
			ev_status_reg <= ev_status_next;
			ev_enable_reg <= ev_enable_next;
			o_irq <= |(ev_status_next & ev_enable_next);
		end
	end

	// Read data stand for the one cycle after the strobe.
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rdata <= `CRHC_WORD_RESET;
		end else begin
			o_rdata <= `CRHC_WORD_RESET;
			if (i_rd) begin
				if (hit(i_addr, `CRHC_OFF_STATUS)) begin
					o_rdata[`CRHC_ST_STATE_LSB +: 2] <= state_reg;
					o_rdata[`CRHC_ST_BOOT_LSB +: 2] <= boot_mode_reg;
					o_rdata[`CRHC_ST_HALTED] <= o_pipeline_halted_flag;
					o_rdata[`CRHC_ST_SLEEP] <= o_sleep;
					o_rdata[`CRHC_ST_RST_SHORT] <= rst_short_reg;
				end else if (hit(i_addr, `CRHC_OFF_IRQ_STATUS)) begin
					o_rdata[`CRHC_NUM_EV-1:0] <= ev_status_reg;
				end else if (hit(i_addr, `CRHC_OFF_IRQ_ENABLE)) begin
					o_rdata[`CRHC_NUM_EV-1:0] <= ev_enable_reg;
				end else if (hit(i_addr, `CRHC_OFF_DATA_ADDR)) begin
					o_rdata <= data_addr_reg;
				end
			end
		end
	end

	a_reset_one_cycle: assert property (@(posedge i_mclk)
		$past(i_srst) |-> (state_reg == crhc_pkg::ST_RESET) && !o_pipeline_halted_flag &&
		!o_irq && (ev_status_reg == `CRHC_EV_RESET))
		else $error("One reset cycle did not fully reset the core.");

	a_boot_mode_sample: assert property (@(posedge i_mclk)
		$past(i_srst) |-> boot_mode_reg == $past(i_boot_mode))
		else $error("Boot mode not sampled during reset.");

	a_halted_flag_state: assert property (@(posedge i_mclk) disable iff (i_srst)
		o_pipeline_halted_flag == (state_reg == crhc_pkg::ST_HALT))
		else $error("Halted output disagrees with pipeline state.");

	a_stop_halts_run: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state_reg == crhc_pkg::ST_RUN) && ctl.halt_req
		|=> (state_reg == crhc_pkg::ST_HALT) && o_pipeline_halted_flag)
		else $error("Stop edge did not halt the pipeline next cycle.");

	a_boot_debug_halt: assert property (@(posedge i_mclk) disable iff (i_srst)
		$fell(i_srst) && (boot_mode_reg == crhc_pkg::BOOT_DEBUG_HALT) &&
		(debug_level_param > 0)
		|-> ##1 (state_reg == crhc_pkg::ST_HALT) && o_pipeline_halted_flag)
		else $error("Boot mode 10 did not enter debug halt.");

	a_boot_vector_run: assert property (@(posedge i_mclk) disable iff (i_srst)
		$fell(i_srst) && (boot_mode_reg == crhc_pkg::BOOT_VECTOR)
		|-> ##1 (state_reg == crhc_pkg::ST_RUN) && (o_instr_addr == vec_base))
		else $error("Boot mode 00 did not start at the reset vector.");

	a_irq_direct_path: assert property (@(posedge i_mclk) disable iff (i_srst)
		(async_irq_param == 0) && $rose(i_interrupt) && (state_reg == crhc_pkg::ST_RUN) &&
		!halt_any |=> o_instr_addr == vec_base + ADDR_W'(`CRHC_IRQ_VEC_OFF))
		else $error("Direct interrupt not acted on in the same cycle.");

	a_addr_width_range: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> (ADDR_W >= 32) && (ADDR_W <= 64) &&
		(o_data_addr == ADDR_W'($past(data_addr_reg))))
		else $error("Address width out of range or data address lost.");

	a_irq_sync_delay: assert property (@(posedge i_mclk) disable iff (i_srst)
		(async_irq_param != 0) && $rose(i_interrupt) && !irq_lvl |=> !irq_lvl)
		else $error("Interrupt bypassed the synchroniser.");

	a_halt_held: assert property (@(posedge i_mclk) disable iff (i_srst)
		(state_reg == crhc_pkg::ST_HALT) && !sw_cont
		|=> (state_reg == crhc_pkg::ST_HALT) && o_pipeline_halted_flag)
		else $error("Halt left or halted output dropped without continue.");

	a_nodbg_never_halt: assert property (@(posedge i_mclk) disable iff (i_srst)
		(debug_level_param == 0) |-> !o_pipeline_halted_flag)
		else $error("Pipeline halted with debug disabled.");

endmodule
`default_nettype wire

// File: sim/crhc_far_model.sv
// Far side model: system reset source, interrupt controller and debug module.
`timescale 1ns/10ps
`default_nettype none
module crhc_far_model (
	// Core clock.
	input  wire logic  i_mclk,
	// Reset and boot mode towards the core.
	output logic       o_srst,
	output logic [1:0] o_boot_mode,
	// Interrupt, debug stop and wakeup towards the core.
	output logic       o_interrupt,
	output logic       o_dbg_stop,
	output logic [1:0] o_wakeup
);
	initial begin
		o_srst = 1'b1;
		o_boot_mode = 2'b00;
		o_interrupt = 1'b0;
		o_dbg_stop = 1'b0;
		o_wakeup = 2'b00;
	end

	// Holds reset for a number of edges, then returns after the first edge with reset low.
	task automatic do_reset(input int cycles, input logic [1:0] mode);
		@(posedge i_mclk);
		o_srst <= 1'b1;
		o_boot_mode <= mode;
		repeat (cycles) @(posedge i_mclk);
		o_srst <= 1'b0;
		@(posedge i_mclk);
		#1;
	endtask

	// A stop request is held high for one whole cycle so its edge is seen.
	task automatic pulse_stop();
		@(posedge i_mclk);
		o_dbg_stop <= 1'b1;
		@(posedge i_mclk);
		o_dbg_stop <= 1'b0;
	endtask

	task automatic set_irq(input logic lvl);
		@(posedge i_mclk);
		o_interrupt <= lvl;
	endtask

	task automatic set_wakeup(input logic [1:0] w);
		@(posedge i_mclk);
		o_wakeup <= w;
	endtask
endmodule
`default_nettype wire

// File: sim/crhc_core_ctl_tb.sv
// Self-checking bench for the core reset and halt control block.
`timescale 1ns/10ps
`default_nettype none
`include "crhc_map.svh"
`define CHECK(nm, got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module crhc_core_ctl_tb;
	logic        i_mclk;
	logic        i_srst;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [31:0] o_rdata;
	logic [1:0]  i_boot_mode;
	logic        i_interrupt;
	logic        i_dbg_stop;
	logic [1:0]  i_wakeup;
	logic        o_pipeline_halted_flag;
	logic        o_sleep;
	logic        o_irq;
	logic [31:0] o_instr_addr;
	logic [31:0] o_data_addr;
	localparam logic [31:0] tb_vec = 32'h0000_1000;
	logic        n_halted;
	logic        n_irq;
	logic [31:0] n_rdata;
	logic        n_sleep;
	logic [63:0] n_instr;
	logic [63:0] n_data;
	int          n_mismatch;
	int          comparisons;
	int          cycles;
	int          n;

	crhc_core_ctl #(.vector_base_param(64'h0000_0000_0000_1000)) u_dut (
		.i_mclk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_boot_mode, .i_interrupt, .i_dbg_stop, .i_wakeup,
		.o_pipeline_halted_flag, .o_sleep, .o_irq, .o_instr_addr, .o_data_addr
	);

	// Second core without debug, without interrupt synchroniser, wide addresses.
	crhc_core_ctl #(.ADDR_W(64), .async_irq_param(0), .debug_level_param(0)) u_nodbg (
		.i_mclk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata(n_rdata),
		.i_boot_mode, .i_interrupt, .i_dbg_stop, .i_wakeup,
		.o_pipeline_halted_flag(n_halted), .o_sleep(n_sleep), .o_irq(n_irq),
		.o_instr_addr(n_instr), .o_data_addr(n_data)
	);

	crhc_far_model u_far (
		.i_mclk, .o_srst(i_srst), .o_boot_mode(i_boot_mode), .o_interrupt(i_interrupt),
		.o_dbg_stop(i_dbg_stop), .o_wakeup(i_wakeup)
	);

	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
		#1;
	endtask

	task automatic bus_read(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		`CHECK(nm, o_rdata, exp)
	endtask

	initial begin
		i_addr = 8'h00;
		i_wdata = 32'h0000_0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		u_far.do_reset(16, 2'b00);
		`CHECK("instr_addr", o_instr_addr, tb_vec)
		`CHECK("wide_instr_addr", n_instr, 64'h0)
		@(posedge i_mclk);
		#1;
		`CHECK("instr_step", o_instr_addr, tb_vec + 32'h0000_0004)
		bus_read(`CRHC_OFF_STATUS, 32'h0000_0001, "status_run");
		bus_read(8'h20, 32'h0000_0000, "unmapped");
		bus_read(`CRHC_OFF_CTRL, 32'h0000_0000, "ctrl_read");
		bus_write(`CRHC_OFF_DATA_ADDR, 32'h8000_0abc);
		`CHECK("data_addr", o_data_addr, 32'h8000_0abc)
		`CHECK("wide_data_addr", n_data, 64'h0000_0000_8000_0abc)
		u_far.pulse_stop();
		#1;
		`CHECK("halted", o_pipeline_halted_flag, 1'b1)
		`CHECK("nodbg_halted", n_halted, 1'b0)
		bus_read(`CRHC_OFF_IRQ_STATUS, 32'h0000_0001, "irq_halt");
		bus_write(`CRHC_OFF_IRQ_ENABLE, 32'h0000_0001);
		`CHECK("irq_on", o_irq, 1'b1)
		`CHECK("nodbg_irq", n_irq, 1'b0)
		bus_write(`CRHC_OFF_IRQ_CLEAR, 32'h0000_0001);
		`CHECK("irq_cleared", o_irq, 1'b0)
		bus_write(`CRHC_OFF_CTRL, 32'h0000_0002);
		`CHECK("continued", o_pipeline_halted_flag, 1'b0)
		bus_read(`CRHC_OFF_IRQ_STATUS, 32'h0000_0004, "irq_resume");
		bus_write(`CRHC_OFF_IRQ_ENABLE, 32'h0000_0004);
		`CHECK("irq_resume_on", o_irq, 1'b1)
		bus_write(`CRHC_OFF_IRQ_ENABLE, 32'h0000_0000);
		`CHECK("irq_masked", o_irq, 1'b0)
		bus_write(`CRHC_OFF_IRQ_CLEAR, 32'h0000_0004);
		bus_write(`CRHC_OFF_STATUS, 32'h0000_00ff);
		bus_read(`CRHC_OFF_STATUS, 32'h0000_0001, "status_ro");
		u_far.set_irq(1'b1);
		@(posedge i_mclk);
		#1;
		`CHECK("direct_irq", n_instr, 64'h10)
		n = 1;
		while (o_instr_addr !== tb_vec + 32'h0000_0010 && n < 8) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		`CHECK("sync_irq", o_instr_addr, tb_vec + 32'h0000_0010)
		`CHECK("sync_delay", (n >= 3), 1'b1)
		bus_read(`CRHC_OFF_IRQ_STATUS, 32'h0000_0002, "irq_taken");
		u_far.set_irq(1'b0);
		u_far.do_reset(1, 2'b10);
		`CHECK("boot_halt", o_pipeline_halted_flag, 1'b1)
		`CHECK("nodbg_boot", n_halted, 1'b0)
		bus_read(`CRHC_OFF_STATUS, 32'h0000_005b, "status_halt");
		`CHECK("nodbg_status", n_rdata, 32'h0000_0049)
		bus_write(`CRHC_OFF_CTRL, 32'h0000_0002);
		`CHECK("boot_resume", o_pipeline_halted_flag, 1'b0)
		u_far.do_reset(16, 2'b01);
		`CHECK("sleep", o_sleep, 1'b1)
		`CHECK("nodbg_sleep", n_sleep, 1'b1)
		u_far.set_wakeup(2'b10);
		n = 0;
		while (o_sleep !== 1'b0 && n < 8) begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		`CHECK("woken", o_sleep, 1'b0)
		u_far.set_wakeup(2'b00);
		complete_run();
	end
endmodule
`default_nettype wire
